// ===== design/acr_pkg.sv
// Shared constants for the converter control and serial readout block
package acr_pkg;

  // Core clock period
  localparam int CLK_PERIOD_NS = 10;

  // Conversion time in the high-sampling mode
  localparam int CONV_FAST_NS = 8000;

  // Conversion time in the auto-sleep mode, wake-up included
  localparam int CONV_SLOW_NS = 14000;

  // Conversion lengths in core clock cycles
  localparam int CONV_FAST_CYC = CONV_FAST_NS / CLK_PERIOD_NS;
  localparam int CONV_SLOW_CYC = CONV_SLOW_NS / CLK_PERIOD_NS;

  // Conversion timer width
  localparam int TMR_W = 11;

  // Result and frame layout
  localparam int RESULT_BITS = 12;
  localparam int FRAME_BITS  = 16;
  localparam int LEAD_ZEROS  = FRAME_BITS - RESULT_BITS;
  localparam int CNT_W       = 4;

  // Shift counter value reached on the fifteenth edge, held until the last edge of a frame
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;

  // Depth of the result buffer
  localparam int BUF_DEPTH = 2;

  // Values after reset
  localparam logic             CONV_IDLE_LVL = 1'b1;
  localparam logic [TMR_W-1:0] TMR_RST       = 11'h000;
  localparam logic [RESULT_BITS-1:0] WORD_RST = 12'h000;

  // Converter control states
  typedef enum logic [1:0]
  {
    ACR_IDLE,
    ACR_CONV,
    ACR_SLEEP
  } acr_state_e;

endpackage

// ===== design/acr_buf.sv
// Small FIFO buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module acr_buf #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse shapes the pointer logic cannot serve
  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("acr_buf: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [PW-1:0]    wr_ptr;        // Next slot to fill
  logic [PW-1:0]    rd_ptr;        // Oldest slot
  logic [PW:0]      fill;          // Words held
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and fill count update, wrapping at DEPTH
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push)
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    if (pop)
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    if (push && !pop)
      next_fill = fill + 1'b1;
    else if (pop && !push)
      next_fill = fill - 1'b1;
  end

  // Registered pointers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // Storage write, no reset needed for data
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule

`default_nettype wire

// ===== design/acr_top.sv
// Converter control and serial result readout, core and shift-clock sides
// Function
// - Convert-start falling edge holds and starts conversion
// - Busy high from start until conversion done
// - Convert-start low at end enters power down
// - Rising convert-start wakes from power down
// - Next frame bit after each shift-clock fall
// - Frame: four zeros, then twelve result bits
// - Release output after sixteenth falling edge
// - Result coded as straight unsigned binary
// - Track/hold returns to track at end
// - Conversion lasts 8 us fast, 14 us sleep
// - Convert-start fall resets output shift register
// - Extra shift pulses advance past reset state
`timescale 1ns/1ps
`default_nettype none

module acr_top
  import acr_pkg::*;
(
  // Core clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // Conversion control pins
  input  wire logic                            convert_start_n,
  input  wire logic [acr_pkg::RESULT_BITS-1:0] sample_code,
  output logic                                 busy,
  output logic                                 track_hold,
  output logic                                 power_down,
  // Serial readout pins
  input  wire logic                            shift_clk,
  output logic                                 serial_result_out,
  output logic                                 serial_result_out_oe_n
);

  import acr_pkg::*;

  // Convert-start synchroniser and edge detect
  logic conv_s1;              // First stage, read only by conv_s2
  logic conv_s2;              // Synchronised level
  logic conv_d;               // Previous synchronised level
  logic fall_evt;             // Falling edge seen
  logic rise_evt;             // Rising edge seen

  // Converter control state
  acr_state_e             state;
  acr_state_e             next_state;
  logic [TMR_W-1:0]       tmr;          // Cycles left in conversion
  logic [TMR_W-1:0]       next_tmr;
  logic                   slow;         // Next conversion follows a wake
  logic                   next_slow;
  logic [RESULT_BITS-1:0] held;         // Value caught at hold
  logic [RESULT_BITS-1:0] next_held;
  logic                   next_busy;
  logic                   next_track_hold;
  logic                   next_power_down;
  logic                   shift_clear;  // One-cycle shift register reset
  logic                   next_shift_clear;
  logic                   push;         // Result offered to buffer
  logic                   conv_end;     // Conversion may finish now

  // Buffer and crossing toward the shift clock
  logic                   buf_in_ready;
  logic                   buf_out_valid;
  logic                   buf_out_ready;
  logic [RESULT_BITS-1:0] buf_out_data;
  logic [RESULT_BITS-1:0] word_hold;    // Stable word for link capture
  logic [RESULT_BITS-1:0] next_word_hold;
  logic                   req_tog;      // Word offered toggle
  logic                   next_req_tog;
  logic                   ack_s1;       // First stage, read only by ack_s2
  logic                   ack_s2;
  logic                   dn_s1;        // First stage, read only by dn_s2
  logic                   dn_s2;
  logic                   dn_d;
  logic                   done_evt;     // Sixteen edges completed
  logic                   next_oe_n;

  // Link side state
  logic                   link_clr;     // Reset of the output shift register
  logic                   rq_s1;        // First stage, read only by rq_s2
  logic                   rq_s2;
  logic                   ack_tog;
  logic                   next_ack_tog;
  logic [RESULT_BITS-1:0] link_word;
  logic [RESULT_BITS-1:0] next_link_word;
  logic                   done_tog;
  logic                   next_done_tog;
  logic [CNT_W-1:0]       cnt;          // Falling edges since clear
  logic [CNT_W-1:0]       next_cnt;
  logic                   next_sdo;
  logic [FRAME_BITS-1:0]  frame;

  // Pin and link toggle synchronisers on the core clock
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_s1 <= CONV_IDLE_LVL;
      conv_s2 <= CONV_IDLE_LVL;
      conv_d  <= CONV_IDLE_LVL;
      ack_s1  <= 1'b0;
      ack_s2  <= 1'b0;
      dn_s1   <= 1'b0;
      dn_s2   <= 1'b0;
      dn_d    <= 1'b0;
    end
    else
    begin
      conv_s1 <= convert_start_n;
      conv_s2 <= conv_s1;
      conv_d  <= conv_s2;
      ack_s1  <= ack_tog;
      ack_s2  <= ack_s1;
      dn_s1   <= done_tog;
      dn_s2   <= dn_s1;
      dn_d    <= dn_s2;
    end
  end

  assign fall_evt = conv_d && !conv_s2;
  assign rise_evt = !conv_d && conv_s2;
  assign done_evt = dn_s2 ^ dn_d;
  assign conv_end = (state == ACR_CONV) && (tmr == TMR_RST) && buf_in_ready;
  assign push     = conv_end;

  // Converter control: start, time, finish, sleep and wake
  always_comb
  begin
    next_state       = state;
    next_tmr         = tmr;
    next_slow        = slow;
    next_held        = held;
    next_busy        = busy;
    next_track_hold  = track_hold;
    next_power_down  = power_down;
    next_shift_clear = 1'b0;
    case (state)
      ACR_IDLE, ACR_CONV:
      begin
        if (fall_evt)
        begin
          // Hold the input and start counting
          next_state       = ACR_CONV;
          next_track_hold  = 1'b1;
          next_busy        = 1'b1;
          next_held        = sample_code;
          next_shift_clear = 1'b1;
          next_tmr         = slow ? TMR_W'(CONV_SLOW_CYC - 1)
                                  : TMR_W'(CONV_FAST_CYC - 1);
        end
        else if (state == ACR_CONV)
        begin
          if (tmr != TMR_RST)
            next_tmr = tmr - 1'b1;
          else if (conv_end)
          begin
            // Result pushed, back to track
            next_busy       = 1'b0;
            next_track_hold = 1'b0;
            next_slow       = 1'b0;
            if (!conv_s2)
            begin
              next_state      = ACR_SLEEP;
              next_power_down = 1'b1;
            end
            else
              next_state = ACR_IDLE;
          end
        end
      end
      ACR_SLEEP:
      begin
        // Wake; the next conversion carries the wake-up time
        if (rise_evt)
        begin
          next_state      = ACR_IDLE;
          next_power_down = 1'b0;
          next_slow       = 1'b1;
        end
      end
      default:
      begin
        next_state = ACR_IDLE;
      end
    endcase
  end

  // Converter control registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= ACR_IDLE;
      tmr         <= TMR_RST;
      slow        <= 1'b0;
      held        <= WORD_RST;
      busy        <= 1'b0;
      track_hold  <= 1'b0;
      power_down  <= 1'b0;
      shift_clear <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      tmr         <= next_tmr;
      slow        <= next_slow;
      held        <= next_held;
      busy        <= next_busy;
      track_hold  <= next_track_hold;
      power_down  <= next_power_down;
      shift_clear <= next_shift_clear;
    end
  end

  // Results wait here while the link has not taken the previous one
  acr_buf #(
    .WIDTH (RESULT_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (held),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // A new word is offered only once the last toggle came back
  assign buf_out_ready = (ack_s2 == req_tog);

  // Word offer and output drive control
  always_comb
  begin
    next_word_hold = word_hold;
    next_req_tog   = req_tog;
    next_oe_n      = serial_result_out_oe_n;
    if (buf_out_valid && buf_out_ready)
    begin
      next_word_hold = buf_out_data;
      next_req_tog   = !req_tog;
    end
    // Clear re-arms the frame, end of frame releases the line
    if (shift_clear)
      next_oe_n = 1'b0;
    else if (done_evt)
      next_oe_n = 1'b1;
  end

  // Word offer registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      word_hold              <= WORD_RST;
      req_tog                <= 1'b0;
      serial_result_out_oe_n <= 1'b1;
    end
    else
    begin
      word_hold              <= next_word_hold;
      req_tog                <= next_req_tog;
      serial_result_out_oe_n <= next_oe_n;
    end
  end

  // Link side: word capture and done report
  assign frame = {{LEAD_ZEROS{1'b0}}, link_word};

  always_comb
  begin
    next_ack_tog   = ack_tog;
    next_link_word = link_word;
    next_done_tog  = done_tog ^ (cnt == CNT_LAST);
    // Take a new word only before its first data bit goes out,
    // so a word offered in mid-frame waits for the next frame
    if (rq_s2 != ack_tog && cnt < CNT_W'(LEAD_ZEROS - 1))
    begin
      next_link_word = word_hold;
      next_ack_tog   = rq_s2;
    end
  end

  // Link capture registers, cleared only by the core reset
  always_ff @(negedge shift_clk or posedge rst)
  begin
    if (rst)
    begin
      rq_s1     <= 1'b0;
      rq_s2     <= 1'b0;
      ack_tog   <= 1'b0;
      link_word <= WORD_RST;
      done_tog  <= 1'b0;
    end
    else
    begin
      rq_s1     <= req_tog;
      rq_s2     <= rq_s1;
      ack_tog   <= next_ack_tog;
      link_word <= next_link_word;
      done_tog  <= next_done_tog;
    end
  end

  // Shift register: one bit per falling edge, hold on the sixteenth
  assign link_clr = rst || shift_clear;

  always_comb
  begin
    next_cnt = cnt + 1'b1;
    if (next_cnt == '0)
      next_sdo = serial_result_out;
    else
      next_sdo = frame[CNT_W'(FRAME_BITS - 1) - next_cnt];
  end

  // Shift registers, also cleared by a conversion start
  always_ff @(negedge shift_clk or posedge link_clr)
  begin
    if (link_clr)
    begin
      cnt               <= '0;
      serial_result_out <= 1'b0;
    end
    else
    begin
      cnt               <= next_cnt;
      serial_result_out <= next_sdo;
    end
  end

  // Helper: cycles busy has been high
  logic [TMR_W:0] busy_len;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy_len <= '0;
    else if (fall_evt)
      busy_len <= '0;
    else if (busy && busy_len != '1)
      busy_len <= busy_len + 1'b1;
  end

  // Checks on the core clock
  chk_busy_on_fall: assert property (@(posedge core_clk) disable iff (rst)
    fall_evt && state != ACR_SLEEP |=> busy && track_hold)
    else $error("busy or hold missing after start");
  chk_hold_tracks_busy: assert property (@(posedge core_clk) disable iff (rst)
    $fell(busy) |-> $fell(track_hold))
    else $error("track/hold not released at end");
  chk_conv_len: assert property (@(posedge core_clk) disable iff (rst)
    $fell(busy) |-> busy_len >= (TMR_W+1)'(CONV_FAST_CYC - 1))
    else $error("conversion shorter than fast time");
  chk_sleep_low: assert property (@(posedge core_clk) disable iff (rst)
    conv_end && !fall_evt && !conv_s2 |=> power_down && state == ACR_SLEEP)
    else $error("no power down with start low");
  chk_wake_rise: assert property (@(posedge core_clk) disable iff (rst)
    power_down && rise_evt |=> !power_down ##0 slow)
    else $error("no wake on rising start");
  chk_clear_drive: assert property (@(posedge core_clk) disable iff (rst)
    fall_evt && state != ACR_SLEEP |=> shift_clear ##1 !serial_result_out_oe_n)
    else $error("output not re-armed on start");
  chk_release_done: assert property (@(posedge core_clk) disable iff (rst)
    done_evt && !shift_clear |=> serial_result_out_oe_n)
    else $error("output not released after frame");
  chk_push_value: assert property (@(posedge core_clk) disable iff (rst)
    fall_evt && state != ACR_SLEEP |=> held == $past(sample_code))
    else $error("held value differs from input");

  // Checks on the shift clock
  chk_lead_zeros: assert property (@(negedge shift_clk) disable iff (link_clr)
    cnt inside {4'h1, 4'h2, 4'h3} |-> !serial_result_out)
    else $error("leading bit not zero");
  chk_wrap_on: assert property (@(negedge shift_clk) disable iff (link_clr)
    cnt == CNT_LAST |=> cnt == '0 ##1 cnt == 4'h1)
    else $error("shift register stopped after frame");

  // Main scenarios
  cov_sleep: cover property (@(posedge core_clk) disable iff (rst)
    $rose(power_down));
  cov_wake_conv: cover property (@(posedge core_clk) disable iff (rst)
    $fell(power_down) ##[1:1000] $rose(busy));
  cov_buf_full: cover property (@(posedge core_clk) disable iff (rst)
    state == ACR_CONV && tmr == TMR_RST && !buf_in_ready);
  cov_frame_done: cover property (@(posedge core_clk) disable iff (rst)
    done_evt);

endmodule

`default_nettype wire

// ===== verif/acr_host.sv
// Host side model: convert-start pulses and framed serial reads
`timescale 1ns/1ps
`default_nettype none

module acr_host #(
  parameter int ACQ_CYC  = 150,
  parameter int HALF_SCK = 80
) (
  // Core clock used to time the pin changes
  input  wire logic core_clk,
  // Conversion control pin
  output logic      convert_start_n,
  // Serial readout pins
  output logic      shift_clk,
  input  wire logic serial_result_out,
  input  wire logic serial_result_out_oe_n
);
  import acr_pkg::*;

  logic last_bit; // Level last driven by the device
  logic line_lvl; // Level seen on the shared data wire

  // Released wire has no pull, so it drifts away from its last level
  always @(posedge core_clk)
    if (!serial_result_out_oe_n)
      last_bit <= serial_result_out;
  assign line_lvl = serial_result_out_oe_n ? ~last_bit : serial_result_out;

  // Idle levels: start high, shift clock parked low
  initial
  begin
    convert_start_n = 1'b1;
    shift_clk       = 1'b0;
    last_bit        = 1'b0;
  end

  // Settling time for the track/hold before any new start
  task automatic acquire();
    repeat (ACQ_CYC) @(negedge core_clk);
  endtask

  // Drive convert-start off the sampling edge
  task automatic set_start(input logic lvl);
    @(negedge core_clk);
    convert_start_n = lvl;
  endtask

  // Read a frame: sample on each fall before the device advances, park low after
  task automatic read_frame(input int n_edges, output logic [FRAME_BITS-1:0] frame);
    frame = '0;
    #43.7;
    for (int k = 0; k < n_edges; k++)
    begin
      #(HALF_SCK);
      shift_clk = 1'b1;
      #(HALF_SCK);
      // Old bit still stands at the instant of the advancing fall
      if (k < FRAME_BITS)
        frame = {frame[FRAME_BITS-2:0], line_lvl};
      shift_clk = 1'b0;
    end
  endtask

endmodule
`default_nettype wire

// ===== verif/adc_conversion_serial_readout_tb_top.sv
// Self-checking bench for the converter control and serial readout block
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_serial_readout_tb_top;
  import acr_pkg::*;

  logic                   core_clk;               // Core clock
  logic                   rst;                    // Async reset
  logic                   convert_start_n;        // From host model
  logic [RESULT_BITS-1:0] sample_code;            // Stand-in input level
  logic                   busy;                   // Conversion running
  logic                   track_hold;             // Hold state
  logic                   power_down;             // Sleep state
  logic                   shift_clk;              // From host model
  logic                   serial_result_out;      // Serial data
  logic                   serial_result_out_oe_n; // Data release
  int                     error_cnt;              // Mismatches
  int                     comparisons;            // Checks made

  // Device under test
  acr_top acr_top_inst (
    .core_clk               (core_clk),
    .rst                    (rst),
    .convert_start_n        (convert_start_n),
    .sample_code            (sample_code),
    .busy                   (busy),
    .track_hold             (track_hold),
    .power_down             (power_down),
    .shift_clk              (shift_clk),
    .serial_result_out      (serial_result_out),
    .serial_result_out_oe_n (serial_result_out_oe_n)
  );

  // Host controller on the far side
  acr_host acr_host_inst (
    .core_clk               (core_clk),
    .convert_start_n        (convert_start_n),
    .shift_clk              (shift_clk),
    .serial_result_out      (serial_result_out),
    .serial_result_out_oe_n (serial_result_out_oe_n)
  );

  // Core clock, 10 ns period
  initial
    core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Single compare for all results
  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Flag picker: 0 busy, 1 power down, else release
  function automatic logic pick(input int sel);
    case (sel)
      0: return busy;
      1: return power_down;
      default: return serial_result_out_oe_n;
    endcase
  endfunction

  // Bounded wait for a flag level; gives the cycles waited
  task automatic wait_lvl(input int sel, input logic lvl, input int max_cyc, output int n);
    n = 0;
    while (pick(sel) !== lvl)
    begin
      @(negedge core_clk);
      n++;
      if (n > max_cyc)
      begin
        error_cnt++;
        $display("MISMATCH at %0t: wait limit on flag %0d", $time, sel);
        end_sim();
      end
    end
  endtask

  // One conversion; pin held low to the end if asked
  task automatic convert(input logic [11:0] code, input logic stay_low, output int cyc);
    int n;
    acr_host_inst.acquire();
    sample_code = code;
    acr_host_inst.set_start(1'b0);
    wait_lvl(0, 1'b1, 8, n);
    check_vec(16'(n < 6), 16'h0001, "busy rise delay");
    check_vec({15'h0, track_hold}, 16'h0001, "hold at start");
    if (!stay_low)
      acr_host_inst.set_start(1'b1);
    else
      @(negedge core_clk);
    wait_lvl(0, 1'b0, 3000, n);
    cyc = n + 1;
    check_vec({15'h0, track_hold}, 16'h0000, "track at end");
    check_vec({15'h0, power_down}, {15'h0, stay_low}, "sleep at end");
  endtask

  // Read a frame, compare it and wait for the release
  task automatic read_check(input logic [11:0] code, input int edges);
    logic [15:0] frame;
    int          n;
    acr_host_inst.read_frame(edges, frame);
    check_vec(frame, {4'h0, code}, "frame");
    wait_lvl(2, 1'b1, 10, n);
  endtask

  // Idle outputs after reset
  task automatic scn_reset();
    check_vec({12'h0, busy, track_hold, power_down, serial_result_out_oe_n}, 16'h0001, "reset");
  endtask

  // Boundary codes, fast timing, extra pulses on the last read
  task automatic scn_codes();
    logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h801};
    int          cyc;
    foreach (codes[i])
    begin
      convert(codes[i], 1'b0, cyc);
      check_vec(16'(cyc), 16'(CONV_FAST_CYC), "fast length");
      read_check(codes[i], (i == 3) ? 20 : 16);
    end
  endtask

  // Sleep at end, wake on rise, slow next conversion
  task automatic scn_sleep();
    int cyc;
    int n;
    convert(12'h5A3, 1'b1, cyc);
    read_check(12'h5A3, 16);
    acr_host_inst.set_start(1'b1);
    wait_lvl(1, 1'b0, 8, n);
    convert(12'h3C7, 1'b0, cyc);
    check_vec(16'(cyc), 16'(CONV_SLOW_CYC), "slow length");
    read_check(12'h3C7, 16);
  endtask

  // Start fall in mid-read and in mid-conversion
  task automatic scn_restart();
    logic [15:0] frame;
    int          cyc;
    int          n;
    convert(12'hFFF, 1'b0, cyc);
    acr_host_inst.read_frame(8, frame);
    sample_code = 12'h2B4;
    acr_host_inst.set_start(1'b0);
    repeat (6) @(negedge core_clk);
    check_vec({14'h0, serial_result_out, serial_result_out_oe_n}, 16'h0000, "read cleared");
    acr_host_inst.set_start(1'b1);
    repeat (100) @(negedge core_clk);
    acr_host_inst.set_start(1'b0);
    acr_host_inst.set_start(1'b1);
    wait_lvl(0, 1'b0, 3000, n);
    check_vec(16'(n >= 800 && n <= 806), 16'h0001, "restart length");
    read_check(12'h2B4, 16);
  endtask

  // Start a conversion and read the oldest queued result while it runs
  task automatic read_during(input logic [11:0] code);
    int n;
    acr_host_inst.acquire();
    acr_host_inst.set_start(1'b0);
    wait_lvl(0, 1'b1, 8, n);
    acr_host_inst.set_start(1'b1);
    read_check(code, 16);
    wait_lvl(0, 1'b0, 3000, n);
    check_vec({15'h0, track_hold}, 16'h0000, "track after read");
  endtask

  // Unread results fill word hold and buffer, stalling the fourth conversion
  task automatic scn_stall();
    int cyc;
    int n;
    convert(12'h123, 1'b0, cyc);
    convert(12'h456, 1'b0, cyc);
    convert(12'h789, 1'b0, cyc);
    acr_host_inst.acquire();
    sample_code = 12'hABC;
    acr_host_inst.set_start(1'b0);
    wait_lvl(0, 1'b1, 8, n);
    acr_host_inst.set_start(1'b1);
    repeat (900) @(negedge core_clk);
    check_vec({15'h0, busy}, 16'h0001, "stalled busy");
    read_check(12'h123, 16);
    wait_lvl(0, 1'b0, 50, n);
    read_during(12'h456);
    read_during(12'h789);
    read_during(12'hABC);
  endtask

  // Main sequence
  initial
  begin
    error_cnt   = 0;
    comparisons = 0;
    sample_code = 12'h000;
    rst         = 1'b1;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    scn_reset();
    scn_codes();
    scn_sleep();
    scn_restart();
    scn_stall();
    end_sim();
  end

endmodule
`default_nettype wire
